// File: dv/t8p_load_model.sv
// external load on the compare pin, pulled low when released
`timescale 1ns/1ps
module t8p_load_model (
  input  wire logic clk_sys,
  input  wire logic clr,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_level,
  output int        high_count,
  output int        rise_count
);
  logic prev_q;
  assign pin_level = pin_oe_n ? 1'b0 : pin_out;
  always @(posedge clk_sys) begin
    prev_q <= pin_level;
    if (clr) begin
      high_count <= 0;
      rise_count <= 0;
    end else begin
      high_count <= high_count + int'(pin_level);
      rise_count <= rise_count + int'(pin_level && !prev_q);
    end
  end
endmodule

// File: dv/t8p_properties.sv
// port checks for the 8-bit timer
`timescale 1ns/1ps
module t8p_props
  import t8p_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst_b,
  input wire t8p_mode_t    waveform_mode_sel,
  input wire t8p_action_t  compare_output_action,
  input wire t8p_clk_sel_t clock_select,
  input wire logic         count_wr_en,
  input wire t8p_count_t   count_wr_data,
  input wire logic         compare_wr_en,
  input wire logic         overflow_ack,
  input wire t8p_count_t   count_value,
  input wire t8p_count_t   compare_value,
  input wire t8p_count_t   compare_buffer,
  input wire logic         overflow_flag,
  input wire logic         compare_match_flag,
  input wire logic         compare_output
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic on1, at_max, m_norm, m_clr, m_fast;
  assign on1    = clock_select == T8P_CS_1 && !count_wr_en;
  assign at_max = count_value == T8P_CNT_MAX;
  assign m_norm = waveform_mode_sel == T8P_WAVE_NORMAL;
  assign m_clr  = waveform_mode_sel == T8P_WAVE_CLEAR;
  assign m_fast = waveform_mode_sel == T8P_WAVE_FAST;
  sequence ctc_hit;
    on1 && m_clr && count_value == compare_value && !$past(count_wr_en)
      && $past(clock_select) == T8P_CS_1;
  endsequence
  norm_wrap_a: assert property (
    on1 && m_norm && at_max |=> count_value == T8P_CNT_BOTTOM && overflow_flag)
    else $error("normal wrap wrong");
  norm_inc_a: assert property (
    on1 && m_norm && !at_max |=> count_value == $past(count_value) + T8P_CNT_STEP)
    else $error("normal step wrong");
  ctc_clear_a: assert property (
    ctc_hit |=> count_value == T8P_CNT_BOTTOM && compare_match_flag)
    else $error("clear on match wrong");
  ctc_toggle_a: assert property (
    ctc_hit ##0 compare_output_action == T8P_ACT_TOGGLE |=> compare_output != $past(compare_output))
    else $error("toggle missing");
  cnt_write_a: assert property (
    count_wr_en |=> count_value == $past(count_wr_data))
    else $error("count write lost");
  fast_top_a: assert property (
    on1 && m_fast && at_max && !compare_wr_en |=> count_value == T8P_CNT_BOTTOM
      && overflow_flag && compare_value == $past(compare_buffer))
    else $error("fast top wrong");
  fast_hold_a: assert property (
    m_fast && !at_max |=> $stable(compare_value))
    else $error("compare changed mid period");
  fast_set_a: assert property (
    on1 && m_fast && at_max && compare_output_action == T8P_ACT_CLEAR |=> compare_output)
    else $error("bottom set missing");
  ovf_keep_a: assert property (
    $fell(overflow_flag) && $past(rst_b) |-> $past(overflow_ack))
    else $error("overflow cleared without ack");
  none_hold_a: assert property (
    compare_output_action == T8P_ACT_NONE |=> $stable(compare_output))
    else $error("output moved with no action");
  ctc_hit_c: cover property (ctc_hit);
  fast_top_c: cover property (on1 && m_fast && at_max);
  ack_c: cover property ($fell(overflow_flag));
endmodule

bind t8p_timer t8p_props u_props (.*);

// File: dv/tb.sv
// self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  import t8p_pkg::*;
  logic         clk_sys, rst_b, count_wr_en, compare_wr_en, force_compare, overflow_ack;
  logic         compare_ack, output_pin_direction, port_level, clr, pin_level;
  logic         overflow_flag, compare_match_flag, compare_output, pin_out, pin_oe_n;
  t8p_mode_t    waveform_mode_sel;
  t8p_action_t  compare_output_action;
  t8p_clk_sel_t clock_select;
  t8p_count_t   count_wr_data, compare_wr_data, count_value, compare_value, compare_buffer, c0;
  int           high_count, rise_count, bad_count, total_checks;
  t8p_action_t  pw_act [6] = '{T8P_ACT_TOGGLE, T8P_ACT_CLEAR, T8P_ACT_SET, T8P_ACT_CLEAR,
                               T8P_ACT_CLEAR, T8P_ACT_NONE};
  t8p_count_t   pw_cmp [6] = '{8'h40, 8'h40, 8'h40, 8'hFF, 8'h00, 8'h40};
  int           pw_hi  [6] = '{256, 130, 382, 512, 2, 512};
  int           pre_n  [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};

  t8p_timer u_dut (.*);
  t8p_load_model u_load (.*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task tk(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task lk;
    @(negedge clk_sys);
  endtask

  task cfg(t8p_mode_t m, t8p_action_t a, t8p_clk_sel_t c);
    @(posedge clk_sys);
    waveform_mode_sel     <= m;
    compare_output_action <= a;
    clock_select          <= c;
  endtask

  task wr(logic to_cmp, t8p_count_t d);
    @(posedge clk_sys);
    count_wr_en     <= !to_cmp;
    compare_wr_en   <= to_cmp;
    count_wr_data   <= d;
    compare_wr_data <= d;
    @(posedge clk_sys);
    count_wr_en   <= 1'b0;
    compare_wr_en <= 1'b0;
  endtask

  task ack;
    @(posedge clk_sys);
    overflow_ack <= 1'b1;
    compare_ack  <= 1'b1;
    @(posedge clk_sys);
    overflow_ack <= 1'b0;
    compare_ack  <= 1'b0;
  endtask

  task fc;
    @(posedge clk_sys);
    force_compare <= 1'b1;
    @(posedge clk_sys);
    force_compare <= 1'b0;
  endtask

  task meas(int n);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    tk(n);
    lk;
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    tk(60000);
    bad_count++;
    wrap_up;
  end

  initial begin
    rst_b                 = 1'b0;
    waveform_mode_sel     = T8P_WAVE_NORMAL;
    compare_output_action = T8P_ACT_NONE;
    clock_select          = T8P_CS_STOP;
    {count_wr_en, compare_wr_en, force_compare, overflow_ack, compare_ack} = 5'h00;
    {output_pin_direction, clr} = 2'h0;
    count_wr_data   = 8'h00;
    compare_wr_data = 8'h00;
    port_level      = 1'b1;
    tk(20);
    rst_b <= 1'b1;
    lk;
    `CHK("reset count", 8'h00, count_value)
    cfg(T8P_WAVE_NORMAL, T8P_ACT_NONE, T8P_CS_1);
    wr(1'b0, 8'hFE);
    tk(2);
    lk;
    `CHK("wrap count", 8'h00, count_value)
    `CHK("overflow set", 1'b1, overflow_flag)
    tk(3);
    lk;
    `CHK("overflow kept", 1'b1, overflow_flag)
    ack;
    lk;
    `CHK("overflow ack", 1'b0, overflow_flag)
    $display("test normal done");
    cfg(T8P_WAVE_CLEAR, T8P_ACT_NONE, T8P_CS_1);
    wr(1'b1, 8'h03);
    ack;
    wr(1'b0, 8'h10);
    tk(240);
    lk;
    `CHK("missed top wrap", 8'h00, count_value)
    `CHK("ctc overflow", 1'b1, overflow_flag)
    `CHK("no early match", 1'b0, compare_match_flag)
    tk(4);
    lk;
    `CHK("ctc clear", 8'h00, count_value)
    `CHK("ctc flag", 1'b1, compare_match_flag)
    wr(1'b0, 8'h03);
    tk(1);
    lk;
    `CHK("blocked match", 8'h04, count_value)
    cfg(T8P_WAVE_CLEAR, T8P_ACT_TOGGLE, T8P_CS_1);
    wr(1'b0, 8'h00);
    meas(64);
    `CHK("pin released", 0, high_count)
    @(posedge clk_sys);
    output_pin_direction <= 1'b1;
    meas(64);
    `CHK("toggle high", 32, high_count)
    `CHK("toggle rises", 8, rise_count)
    $display("test clear on match done");
    for (int i = 0; i < 6; i++) begin
      cfg(T8P_WAVE_FAST, pw_act[i], T8P_CS_1);
      wr(1'b1, pw_cmp[i]);
      lk;
      `CHK("buffer", pw_cmp[i], compare_buffer)
      tk(260);
      meas(512);
      `CHK("pwm high", pw_hi[i], high_count)
    end
    $display("test fast pwm done");
    for (int i = 0; i < 8; i++) begin
      cfg(T8P_WAVE_NORMAL, T8P_ACT_NONE, t8p_clk_sel_t'(i));
      lk;
      c0 = count_value;
      tk(16 * pre_n[i]);
      lk;
      `CHK("ticks", (i == 0) ? 8'h00 : 8'h10, count_value - c0)
    end
    $display("test prescaler done");
    cfg(T8P_WAVE_NORMAL, T8P_ACT_CLEAR, T8P_CS_STOP);
    ack;
    lk;
    c0 = count_value;
    fc;
    lk;
    `CHK("force clear", 1'b0, compare_output)
    cfg(T8P_WAVE_NORMAL, T8P_ACT_SET, T8P_CS_STOP);
    fc;
    lk;
    `CHK("force set", 3'h6, {compare_output, pin_out, compare_match_flag})
    cfg(T8P_WAVE_NORMAL, T8P_ACT_NONE, T8P_CS_STOP);
    fc;
    lk;
    `CHK("force none", 1'b1, compare_output)
    `CHK("force no count", c0, count_value)
    cfg(T8P_WAVE_PHASE, T8P_ACT_NONE, T8P_CS_STOP);
    wr(1'b1, 8'h5A);
    lk;
    `CHK("phase buffered", {8'h5A, pw_cmp[5]}, {compare_buffer, compare_value})
    cfg(T8P_WAVE_CLEAR, T8P_ACT_NONE, T8P_CS_STOP);
    wr(1'b1, 8'h21);
    lk;
    `CHK("direct compare", 8'h21, compare_value)
    @(posedge clk_sys);
    rst_b <= 1'b0;
    tk(2);
    lk;
    `CHK("reset words", 24'h000000, {count_value, compare_value, compare_buffer})
    `CHK("reset flags", 2'h0, {overflow_flag, compare_match_flag})
    `CHK("reset pin", 3'h1, {compare_output, pin_out, pin_oe_n})
    @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(1'b0, T8P_CNT_BOTTOM);
    tk(3);
    cfg(T8P_WAVE_CLEAR, T8P_ACT_NONE, T8P_CS_1);
    tk(1);
    lk;
    `CHK("stopped write blocks", 9'h001, {compare_match_flag, count_value})
    $display("test force and reset done");
    wrap_up;
  end
endmodule

// File: shared/t8p_pkg.sv
// constants and types shared by the 8-bit timer design
package t8p_pkg;

  typedef logic [1:0] t8p_mode_t;
  typedef logic [1:0] t8p_action_t;
  typedef logic [2:0] t8p_clk_sel_t;
  typedef logic [7:0] t8p_count_t;

  // waveform mode encodings
  localparam t8p_mode_t T8P_WAVE_NORMAL = 2'h0;
  localparam t8p_mode_t T8P_WAVE_PHASE  = 2'h1;
  localparam t8p_mode_t T8P_WAVE_CLEAR  = 2'h2;
  localparam t8p_mode_t T8P_WAVE_FAST   = 2'h3;

  // output action encodings
  localparam t8p_action_t T8P_ACT_NONE   = 2'h0;
  localparam t8p_action_t T8P_ACT_TOGGLE = 2'h1;
  localparam t8p_action_t T8P_ACT_CLEAR  = 2'h2;
  localparam t8p_action_t T8P_ACT_SET    = 2'h3;

  // clock select encodings
  localparam t8p_clk_sel_t T8P_CS_STOP = 3'h0;
  localparam t8p_clk_sel_t T8P_CS_1    = 3'h1;
  localparam t8p_clk_sel_t T8P_CS_8    = 3'h2;
  localparam t8p_clk_sel_t T8P_CS_32   = 3'h3;
  localparam t8p_clk_sel_t T8P_CS_64   = 3'h4;
  localparam t8p_clk_sel_t T8P_CS_128  = 3'h5;
  localparam t8p_clk_sel_t T8P_CS_256  = 3'h6;
  localparam t8p_clk_sel_t T8P_CS_1024 = 3'h7;

  // prescaler
  localparam int          T8P_PRE_W   = 10;
  localparam logic [9:0]  T8P_PRE_RST = 10'h000;
  localparam logic [9:0]  T8P_MASK_8    = 10'h007;
  localparam logic [9:0]  T8P_MASK_32   = 10'h01F;
  localparam logic [9:0]  T8P_MASK_64   = 10'h03F;
  localparam logic [9:0]  T8P_MASK_128  = 10'h07F;
  localparam logic [9:0]  T8P_MASK_256  = 10'h0FF;
  localparam logic [9:0]  T8P_MASK_1024 = 10'h3FF;

  // counter limits and reset values
  localparam t8p_count_t T8P_CNT_MAX    = 8'hFF;
  localparam t8p_count_t T8P_CNT_BOTTOM = 8'h00;
  localparam t8p_count_t T8P_CNT_RST    = 8'h00;
  localparam t8p_count_t T8P_CMP_RST    = 8'h00;
  localparam t8p_count_t T8P_CNT_STEP   = 8'h01;
  localparam logic       T8P_FLAG_RST   = 1'b0;
  localparam logic       T8P_OUT_RST    = 1'b0;

endpackage

// File: verilog/t8p_prescaler.sv
// timer clock enable divider from the system clock
`timescale 1ns/1ps
module t8p_prescaler
  import t8p_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire t8p_clk_sel_t  clock_select,
  output logic               timer_tick
);

  logic [T8P_PRE_W-1:0] div_q;
  logic [T8P_PRE_W-1:0] div_d;
  logic [T8P_PRE_W-1:0] mask;

  always_comb begin
    div_d = div_q + 10'h001;
    mask  = T8P_MASK_1024;
    case (clock_select)
      T8P_CS_8:   mask = T8P_MASK_8;
      T8P_CS_32:  mask = T8P_MASK_32;
      T8P_CS_64:  mask = T8P_MASK_64;
      T8P_CS_128: mask = T8P_MASK_128;
      T8P_CS_256: mask = T8P_MASK_256;
      default:    mask = T8P_MASK_1024;
    endcase
    // one-cycle enable per divided period
    if (clock_select == T8P_CS_STOP) begin
      timer_tick = 1'b0;
    end else if (clock_select == T8P_CS_1) begin
      timer_tick = 1'b1;
    end else begin
      timer_tick = ((div_q & mask) == mask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_q <= T8P_PRE_RST;
    end else begin
      div_q <= div_d;
    end
  end

endmodule

// File: verilog/t8p_timer.sv
// 8-bit timer with normal, clear-on-match and fast pwm modes
// How it works
// - mode picks sequence; action picks output only
// - mode 0 counts up, wraps FF to 00
// - normal overflow flag set as count becomes zero
// - counting only sets overflow; interrupt taken clears
// - normal mode accepts count writes anytime
// - mode 2 clears count on compare match
// - mode 2 compare writes direct; missed match wraps
// - mode 2 sets compare flag at top
// - mode 2 action 1 toggles output each match
// - mode 2 overflow flag set on FF to 00
// - timer enable divides by 1..1024
// - mode 3 counts bottom to max, then clears
// - fast pwm action 2 clears/sets, 3 inverts
// - fast pwm overflow flag set at max
// - compare bottom spikes; compare max holds level
// - fast pwm period is 256 timer cycles
// - fast pwm action 1 toggles, half duty
// - fast pwm compare register is double buffered
// - buffered compare loads only at top/bottom
// - count write blocks next timer cycle match
// - action 0 leaves output alone at match
`timescale 1ns/1ps
module t8p_timer
  import t8p_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire t8p_mode_t     waveform_mode_sel,
  input  wire t8p_action_t   compare_output_action,
  input  wire t8p_clk_sel_t  clock_select,
  input  wire logic          count_wr_en,
  input  wire t8p_count_t    count_wr_data,
  input  wire logic          compare_wr_en,
  input  wire t8p_count_t    compare_wr_data,
  input  wire logic          force_compare,
  input  wire logic          overflow_ack,
  input  wire logic          compare_ack,
  input  wire logic          output_pin_direction,
  input  wire logic          port_level,
  output t8p_count_t         count_value,
  output t8p_count_t         compare_value,
  output t8p_count_t         compare_buffer,
  output logic               overflow_flag,
  output logic               compare_match_flag,
  output logic               compare_output,
  output logic               pin_out,
  output logic               pin_oe_n
);

  // pwm modes use the buffered compare path
  function automatic logic t8p_is_pwm(input t8p_mode_t m);
    t8p_is_pwm = (m == T8P_WAVE_FAST) || (m == T8P_WAVE_PHASE);
  endfunction

  // timer enable
  logic timer_tick;

  t8p_prescaler u_pre (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .clock_select (clock_select),
    .timer_tick   (timer_tick)
  );

  // counter state
  t8p_count_t cnt_q;
  t8p_count_t cnt_d;
  logic       block_q;
  logic       block_d;

  // compare state
  t8p_count_t ocr_q;
  t8p_count_t ocr_d;
  t8p_count_t buf_q;
  t8p_count_t buf_d;

  // flag state
  logic ovf_q;
  logic ovf_d;
  logic cmf_q;
  logic cmf_d;

  // output state
  logic oc_q;
  logic oc_d;
  logic pin_q;
  logic pin_d;
  logic oe_n_q;
  logic oe_n_d;

  // events
  logic at_max;
  logic equal;
  logic match_evt;
  logic wrap_evt;
  logic bottom_evt;
  logic force_evt;
  logic pwm_mode;

  always_comb begin
    pwm_mode = t8p_is_pwm(waveform_mode_sel);
    at_max   = (cnt_q == T8P_CNT_MAX);
    equal    = (cnt_q == ocr_q);
    // match only on an enable not blocked by a count write
    match_evt = timer_tick && equal && !block_q;
    // counter leaves max for bottom
    wrap_evt = timer_tick && at_max && !count_wr_en;
    bottom_evt = wrap_evt && (waveform_mode_sel == T8P_WAVE_FAST);
    // force only acts outside pwm modes
    force_evt = force_compare && !pwm_mode;
  end

  // count sequence
  always_comb begin
    cnt_d = cnt_q;
    if (count_wr_en) begin
      cnt_d = count_wr_data;
    end else if (timer_tick) begin
      case (waveform_mode_sel)
        T8P_WAVE_CLEAR: begin
          if (match_evt) begin
            cnt_d = T8P_CNT_BOTTOM;
          end else begin
            // missed top runs on through max and wraps
            cnt_d = cnt_q + T8P_CNT_STEP;
          end
        end
        T8P_WAVE_FAST: begin
          if (at_max) begin
            cnt_d = T8P_CNT_BOTTOM;
          end else begin
            cnt_d = cnt_q + T8P_CNT_STEP;
          end
        end
        default: begin
          cnt_d = cnt_q + T8P_CNT_STEP;
        end
      endcase
    end
  end

  // match blocking after a count write
  always_comb begin
    block_d = block_q;
    if (count_wr_en) begin
      block_d = 1'b1;
    end else if (timer_tick) begin
      block_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q   <= T8P_CNT_RST;
      block_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      block_q <= block_d;
    end
  end

  // compare register and its buffer
  always_comb begin
    ocr_d = ocr_q;
    buf_d = buf_q;
    if (compare_wr_en) begin
      buf_d = compare_wr_data;
    end
    if (pwm_mode) begin
      // buffered value moves over at the wrap only
      if (wrap_evt) begin
        ocr_d = buf_q;
      end
    end else begin
      if (compare_wr_en) begin
        ocr_d = compare_wr_data;
      end else begin
        ocr_d = buf_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ocr_q <= T8P_CMP_RST;
      buf_q <= T8P_CMP_RST;
    end else begin
      ocr_q <= ocr_d;
      buf_q <= buf_d;
    end
  end

  // sticky flags, a set beats a clear in the same cycle
  always_comb begin
    ovf_d = ovf_q;
    cmf_d = cmf_q;
    if (overflow_ack) begin
      ovf_d = 1'b0;
    end
    if (wrap_evt) begin
      ovf_d = 1'b1;
    end
    if (compare_ack) begin
      cmf_d = 1'b0;
    end
    if (match_evt) begin
      cmf_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ovf_q <= T8P_FLAG_RST;
      cmf_q <= T8P_FLAG_RST;
    end else begin
      ovf_q <= ovf_d;
      cmf_q <= cmf_d;
    end
  end

  // waveform generator
  t8p_wavegen u_wave (
    .waveform_mode_sel     (waveform_mode_sel),
    .compare_output_action (compare_output_action),
    .match_evt             (match_evt),
    .bottom_evt            (bottom_evt),
    .force_evt             (force_evt),
    .level_now             (oc_q),
    .level_next            (oc_d)
  );

  // pin override and direction
  always_comb begin
    if (compare_output_action != T8P_ACT_NONE) begin
      pin_d = oc_d;
    end else begin
      pin_d = port_level;
    end
    // pin drives only when software made it an output
    oe_n_d = !output_pin_direction;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      oc_q   <= T8P_OUT_RST;
      pin_q  <= T8P_OUT_RST;
      oe_n_q <= 1'b1;
    end else begin
      oc_q   <= oc_d;
      pin_q  <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  // outputs
  assign count_value        = cnt_q;
  assign compare_value      = ocr_q;
  assign compare_buffer     = buf_q;
  assign overflow_flag      = ovf_q;
  assign compare_match_flag = cmf_q;
  assign compare_output     = oc_q;
  assign pin_out            = pin_q;
  assign pin_oe_n           = oe_n_q;

endmodule

// File: verilog/t8p_wavegen.sv
// next compare output level from match, bottom and force events
`timescale 1ns/1ps
module t8p_wavegen
  import t8p_pkg::*;
(
  input  wire t8p_mode_t    waveform_mode_sel,
  input  wire t8p_action_t  compare_output_action,
  input  wire logic         match_evt,
  input  wire logic         bottom_evt,
  input  wire logic         force_evt,
  input  wire logic         level_now,
  output logic              level_next
);

  logic fire;

  always_comb begin
    level_next = level_now;
    fire       = match_evt || force_evt;
    if (waveform_mode_sel == T8P_WAVE_FAST) begin
      case (compare_output_action)
        T8P_ACT_TOGGLE: begin
          if (match_evt) begin
            level_next = ~level_now;
          end
        end
        T8P_ACT_CLEAR: begin
          // bottom wins so a top compare gives a steady level
          if (bottom_evt) begin
            level_next = 1'b1;
          end else if (match_evt) begin
            level_next = 1'b0;
          end
        end
        T8P_ACT_SET: begin
          if (bottom_evt) begin
            level_next = 1'b0;
          end else if (match_evt) begin
            level_next = 1'b1;
          end
        end
        default: level_next = level_now;
      endcase
    end else if (fire) begin
      case (compare_output_action)
        T8P_ACT_TOGGLE: level_next = ~level_now;
        T8P_ACT_CLEAR:  level_next = 1'b0;
        T8P_ACT_SET:    level_next = 1'b1;
        default:        level_next = level_now;
      endcase
    end
  end

endmodule
